//--- rtl/scd_pkg.sv
// package: register map, field positions, states and timing for the stop collision block
package scd_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFF_TRANSFER_BUFFER = 8'h00;
  localparam logic [7:0] OFF_RATE_RELOAD = 8'h04;
  localparam logic [7:0] OFF_PORT_CONTROL_ONE = 8'h08;
  localparam logic [7:0] OFF_PORT_CONTROL_TWO = 8'h0C;
  localparam logic [7:0] OFF_PORT_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] OFF_LINE_STATE = 8'h20;
  // field positions
  localparam int STOP_SEQ_EN_BIT = 2;
  localparam int PORT_STOP_SEEN_BIT = 4;
  localparam int PORT_START_SEEN_BIT = 3;
  localparam int IRQ_PORT_EVENT_BIT = 0;
  localparam int IRQ_COLLISION_BIT = 1;
  localparam int CTRL_ONE_ENABLE_BIT = 5;
  localparam int RELOAD_W = 7;
  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [6:0] RST_RELOAD = 7'h00;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;
  // timing: system clock rate and synchroniser depth on the bus pins
  localparam int CLK_HZ = 20_000_000;
  localparam int SYNC_STAGES = 2;

  // stop sequence states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SDA_LOW = 3'b001,
    ST_SCL_REL = 3'b010,
    ST_COUNT = 3'b011,
    ST_SDA_REL = 3'b100,
    ST_CHECK = 3'b101,
    ST_FINISH = 3'b110
  } scd_state_t;

  // bus lines as seen after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } scd_lines_t;

  // apb request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } scd_apb_req_t;
endpackage

//--- rtl/scd_line_sync.sv
// module: two-flop synchroniser and edge finder for the scl and sda pins
`timescale 1ns/1ps
module scd_line_sync
  import scd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // synchronised view
  output scd_lines_t lines,
  output logic stop_seen,
  output logic start_seen
);
  logic [1:0] meta;
  scd_lines_t prev;

  // first stage feeds only the second; released lines idle high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 2'h3;
      lines <= '1;
      prev <= '1;
    end else begin
      meta <= {scl_in, sda_in};
      lines <= meta;
      prev <= lines;
    end
  end

  // stop is sda rising while scl high, start is sda falling while scl high
  always_comb begin
    stop_seen = lines.scl && prev.scl && lines.sda && !prev.sda;
    start_seen = lines.scl && prev.scl && !lines.sda && prev.sda;
  end
endmodule // scd_line_sync

//--- rtl/scd_stop_collision.sv
// module: i2c master stop sequence with bus collision detection and apb registers
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module scd_stop_collision
  import scd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c pins, open drain: oe_n low means pull low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // interrupt
  output logic irq
);
  scd_apb_req_t req;
  scd_lines_t lines;
  scd_state_t state;
  logic stop_seen;
  logic start_seen;
  logic [7:0] transfer_buffer;
  logic [7:0] rate_reload;
  logic [7:0] port_control_one;
  logic stop_sequence_enable;
  logic [7:0] ctrl_two_other;
  logic stop_flag;
  logic start_flag;
  logic write_collision;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [RELOAD_W-1:0] bit_rate_counter;
  logic drive_sda_low;
  logic drive_scl_low;
  logic collision;
  logic seq_done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // one bundled view of the apb inputs shared by decode, write and read paths
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // address decode, used only for the pslverr response to writes and reads
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == OFF_TRANSFER_BUFFER) is_mapped = 1'b1;
    else if (a == OFF_RATE_RELOAD) is_mapped = 1'b1;
    else if (a == OFF_PORT_CONTROL_ONE) is_mapped = 1'b1;
    else if (a == OFF_PORT_CONTROL_TWO) is_mapped = 1'b1;
    else if (a == OFF_PORT_STATUS) is_mapped = 1'b1;
    else if (a == OFF_IRQ_STATUS) is_mapped = 1'b1;
    else if (a == OFF_IRQ_ENABLE) is_mapped = 1'b1;
    else if (a == OFF_IRQ_CLEAR) is_mapped = 1'b1;
    else if (a == OFF_LINE_STATE) is_mapped = 1'b1;
    else is_mapped = 1'b0;
  endfunction

  scd_line_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .lines(lines),
    .stop_seen(stop_seen),
    .start_seen(start_seen)
  );

  // zero-wait apb: every access completes in its first access cycle
  assign pready = 1'b1;
  assign addr_ok = is_mapped(req.addr);
  assign wr_en = req.sel && req.enable && req.write;
  assign rd_en = req.sel && !req.enable && !req.write;
  assign pslverr = req.sel && req.enable && !addr_ok;

  // plain software registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_reload <= RST_REG8;
      port_control_one <= RST_REG8;
      ctrl_two_other <= RST_REG8;
      irq_enable <= RST_IRQ;
      transfer_buffer <= RST_REG8;
    end else if (wr_en) begin
      if (req.addr == OFF_RATE_RELOAD) begin
        rate_reload <= req.wdata[7:0];
      end else if (req.addr == OFF_PORT_CONTROL_ONE) begin
        port_control_one <= req.wdata[7:0];
      end else if (req.addr == OFF_PORT_CONTROL_TWO) begin
        ctrl_two_other <= req.wdata[7:0];
      end else if (req.addr == OFF_IRQ_ENABLE) begin
        irq_enable <= req.wdata[1:0];
      end else if (req.addr == OFF_TRANSFER_BUFFER && state == ST_IDLE) begin
        transfer_buffer <= req.wdata[7:0]; // blocked while a stop is running
      end
    end
  end

  // write collision: buffer write refused during a stop sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_collision <= 1'b0;
    end else if (wr_en && req.addr == OFF_TRANSFER_BUFFER && state != ST_IDLE) begin
      write_collision <= 1'b1;
    end else if (wr_en && req.addr == OFF_PORT_CONTROL_ONE && !req.wdata[7]) begin
      write_collision <= 1'b0;
    end
  end

  // stop enable: set by software, cleared by hardware on finish or collision
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_sequence_enable <= 1'b0;
    end else if (collision || seq_done) begin
      stop_sequence_enable <= 1'b0;
    end else if (wr_en && req.addr == OFF_PORT_CONTROL_TWO) begin
      stop_sequence_enable <= req.wdata[STOP_SEQ_EN_BIT];
    end
  end

  // stop and start seen bits in the status register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_flag <= 1'b0;
      start_flag <= 1'b0;
    end else if (!port_control_one[CTRL_ONE_ENABLE_BIT]) begin
      stop_flag <= 1'b0; // cleared while the port is disabled
      start_flag <= 1'b0;
    end else if (stop_seen) begin
      stop_flag <= 1'b1;
      start_flag <= 1'b0;
    end else if (start_seen) begin
      start_flag <= 1'b1;
      stop_flag <= 1'b0;
    end
  end

  // stop sequence engine
  // every level seen here lags the pins by the registered enables and two
  // synchroniser flops, so a wait only trusts a line once the level that this
  // block caused itself has come through the pipeline
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_rate_counter <= RST_RELOAD;
    end else begin
      case (state)
        ST_IDLE: begin
          if (stop_sequence_enable && port_control_one[CTRL_ONE_ENABLE_BIT]) begin
            state <= ST_SDA_LOW;
          end
        end
        ST_SDA_LOW: begin
          // wait for our own scl pull too: a stale high scl would otherwise skip
          // clock arbitration and read as a collision once the low arrives
          if (!lines.sda && !lines.scl) begin
            state <= ST_SCL_REL;
          end
        end
        ST_SCL_REL: begin
          if (lines.scl) begin
            bit_rate_counter <= rate_reload[RELOAD_W-1:0];
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (collision) begin
            state <= ST_IDLE;
          end else if (bit_rate_counter == RST_RELOAD) begin
            bit_rate_counter <= rate_reload[RELOAD_W-1:0];
            state <= ST_SDA_REL;
          end else begin
            bit_rate_counter <= bit_rate_counter - 7'h01;
          end
        end
        ST_SDA_REL: begin
          if (collision) begin
            state <= ST_IDLE;
          end else if (bit_rate_counter == RST_RELOAD) begin
            state <= ST_CHECK;
          end else begin
            bit_rate_counter <= bit_rate_counter - 7'h01;
          end
        end
        ST_CHECK: begin
          if (collision) begin
            state <= ST_IDLE;
          end else begin
            bit_rate_counter <= rate_reload[RELOAD_W-1:0];
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          if (bit_rate_counter == RST_RELOAD) begin
            state <= ST_IDLE;
          end else begin
            bit_rate_counter <= bit_rate_counter - 7'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // collision cases: scl pulled low before sda release, sda low after timeout
  // in the release window a low scl still counts until sda is seen high
  always_comb begin
    collision = 1'b0;
    if (state == ST_COUNT && !lines.scl) begin
      collision = 1'b1;
    end else if (state == ST_SDA_REL && !lines.scl && !lines.sda) begin
      collision = 1'b1;
    end else if (state == ST_CHECK && !lines.sda) begin
      collision = 1'b1;
    end
  end
  assign seq_done = state == ST_FINISH && bit_rate_counter == RST_RELOAD;

  // line drivers: only pull low or release
  // enables are registered so the pins never glitch while the state decodes
  always_comb begin
    drive_sda_low = state == ST_SDA_LOW || state == ST_SCL_REL || state == ST_COUNT;
    drive_scl_low = state == ST_SDA_LOW;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
    end else begin
      sda_oe_n <= !(drive_sda_low && !collision);
      scl_oe_n <= !(drive_scl_low && !collision);
    end
  end
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  // sticky interrupt sources: set wins over clear
  // the interrupt is a plain level: software clears the cause, not the pin
  always_comb begin
    irq_set = 2'h0;
    irq_set[IRQ_COLLISION_BIT] = collision;
    irq_set[IRQ_PORT_EVENT_BIT] = seq_done || stop_seen;
    irq_clr = (wr_en && req.addr == OFF_IRQ_CLEAR) ? req.wdata[1:0] : 2'h0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_status & irq_enable);

  // read data, registered in the setup cycle
  // loading it there lets pready stay high with no wait state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= APB_ZERO;
    end else if (rd_en) begin
      if (req.addr == OFF_TRANSFER_BUFFER) begin
        prdata <= {24'h0, transfer_buffer};
      end else if (req.addr == OFF_RATE_RELOAD) begin
        prdata <= {24'h0, rate_reload};
      end else if (req.addr == OFF_PORT_CONTROL_ONE) begin
        prdata <= {24'h0, write_collision, port_control_one[6:0]};
      end else if (req.addr == OFF_PORT_CONTROL_TWO) begin
        prdata <= {24'h0, ctrl_two_other[7:3], stop_sequence_enable, ctrl_two_other[1:0]};
      end else if (req.addr == OFF_PORT_STATUS) begin
        prdata <= {27'h0, stop_flag, start_flag, 3'h0};
      end else if (req.addr == OFF_IRQ_STATUS) begin
        prdata <= {30'h0, irq_status};
      end else if (req.addr == OFF_IRQ_ENABLE) begin
        prdata <= {30'h0, irq_enable};
      end else if (req.addr == OFF_LINE_STATE) begin
        prdata <= {27'h0, state, lines};
      end else begin
        prdata <= APB_ZERO;
      end
    end
  end
endmodule // scd_stop_collision

//--- test/scd_stop_collision_monitor.sv
// checker: port-level relations of the stop sequence and its collisions
`timescale 1ns/1ps
module scd_stop_collision_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus pins and interrupt
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // scl is let go only once sda has been pulled long enough to be seen
  property p_scl_rel;
    $rose(scl_oe_n) && !sda_oe_n |-> !$past(sda_oe_n, 2);
  endproperty
  a_scl_rel: assert property (p_scl_rel) else $error("scl released early");
  // a stretched clock holds the sequence: no count, sda stays pulled
  property p_stretch;
    $rose(scl_oe_n) ##1 (!scl_in)[*8] |-> !sda_oe_n;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch not honoured");
  // count starts on scl high; reload of three gives a short bounded span
  property p_count;
    $rose(scl_in) && scl_oe_n && !sda_oe_n |-> (!sda_oe_n)[*3] ##[1:8] sda_oe_n;
  endproperty
  a_count: assert property (p_count) else $error("sda release timing");
  // scl pulled low by another party before sda release ends the sequence
  property p_scl_coll;
    scl_oe_n && !sda_oe_n && $past(scl_in) && !scl_in |-> ##[1:5] sda_oe_n;
  endproperty
  a_scl_coll: assert property (p_scl_coll) else $error("scl collision missed");
  // sda is never let go while scl is still driven
  property p_both_rel;
    $rose(sda_oe_n) |-> scl_oe_n;
  endproperty
  a_both_rel: assert property (p_both_rel) else $error("scl still driven");
  // after sda goes, the port sits idle with both lines free
  property p_idle;
    $rose(sda_oe_n) |=> (sda_oe_n && scl_oe_n)[*8];
  endproperty
  a_idle: assert property (p_idle) else $error("port not idle");
  // open drain: data pins only ever carry a low
  property p_od;
    !scl_out && !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("pin drives high");
  // reset leaves lines released and the interrupt quiet
  property p_rst;
    $rose(rst_n) |-> scl_oe_n && sda_oe_n && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // scd_stop_collision_monitor

//--- test/scd_bus_model.sv
// bus model: pulled-up scl and sda with another party able to hold either low
`timescale 1ns/1ps
module scd_bus_model (
  // design pin enables
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // other party pulls
  input wire logic hold_scl,
  input wire logic hold_sda,
  // resolved line levels
  output logic scl,
  output logic sda
);
  // wired-and: a released line floats high unless someone holds it
  assign scl = scl_oe_n & ~hold_scl;
  assign sda = sda_oe_n & ~hold_sda;
endmodule // scd_bus_model

//--- test/scd_stop_collision_tb.sv
// testbench: stop sequence, collisions and interrupt handling over apb
`timescale 1ns/1ps
module scd_stop_collision_tb;
  import scd_pkg::*;
  logic clk, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, irq, scl, sda, hold_scl = 0, hold_sda = 0;
  int failures = 0, num_checks = 0, n;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  scd_stop_collision scd_stop_collision_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
  scd_bus_model scd_bus_model_inst (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .hold_scl(hold_scl), .hold_sda(hold_sda), .scl(scl), .sda(sda));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // bounded wait: 0 sda pulled, 1 scl released, 2 irq high
  task automatic wt(input int w);
    n = 0;
    while (n < 300 && !(w == 0 ? sda_oe_n === 1'b0 : w == 1 ? scl_oe_n === 1'b1 :
        irq === 1'b1)) begin
      @(posedge clk);
      n++;
    end
    chk(n < 300, 1'b1);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: the run needs a few thousand cycles at most
  initial begin
    #(50 * 20000);
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, OFF_IRQ_STATUS, 0);
    chk(rd, 32'h0);
    apb(1, OFF_RATE_RELOAD, 32'h3);
    apb(1, OFF_PORT_CONTROL_ONE, 32'h20);
    apb(1, OFF_IRQ_ENABLE, 32'h2);
    apb(0, 8'h40, 0);
    chk(err, 1'b1);
    // clean stop with its event masked off the interrupt line
    apb(1, OFF_PORT_CONTROL_TWO, 32'h4);
    for (int i = 0; i < 20 && rd[0] !== 1'b1; i++) apb(0, OFF_IRQ_STATUS, 0);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    apb(0, OFF_PORT_STATUS, 0);
    chk(rd[PORT_STOP_SEEN_BIT], 1'b1);
    apb(1, OFF_IRQ_ENABLE, 32'h3);
    chk(irq, 1'b1);
    // k 0: sda held low, k 1: scl pulled in count, k 2: clock stretched
    for (int k = 0; k < 3; k++) begin
      apb(1, OFF_IRQ_CLEAR, 32'h3);
      chk(irq, 1'b0);
      hold_sda <= (k == 0);
      hold_scl <= (k == 2);
      apb(1, OFF_PORT_CONTROL_TWO, 32'h4);
      wt(0);
      if (k == 1) begin
        wt(1);
        repeat (2) @(posedge clk);
        hold_scl <= 1'b1;
      end
      if (k == 2) begin
        repeat (20) @(posedge clk);
        chk(sda_oe_n, 1'b0);
        hold_scl <= 1'b0;
      end
      wt(2);
      apb(0, OFF_IRQ_STATUS, 0);
      chk(rd, (k == 2) ? 32'h1 : 32'h2);
      chk({scl_oe_n, sda_oe_n}, 2'b11);
      apb(0, OFF_PORT_CONTROL_TWO, 0);
      chk(rd[STOP_SEQ_EN_BIT], 1'b0);
      apb(0, OFF_LINE_STATE, 0);
      chk(rd[4:2], ST_IDLE);
      hold_sda <= 1'b0;
      hold_scl <= 1'b0;
      repeat (6) @(posedge clk);
      apb(0, OFF_IRQ_STATUS, 0);
      // sda rising under a high scl is a bus stop seen after the collision
      if (k == 0) chk(rd[IRQ_PORT_EVENT_BIT], 1'b1);
    end
    summarize();
  end
endmodule // scd_stop_collision_tb
bind scd_stop_collision scd_stop_collision_monitor scd_stop_collision_monitor_inst (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
